// File: design/hvsp_params.svh
`ifndef HVSP_PARAMS_SVH
`define HVSP_PARAMS_SVH
// Frame layout
`define HVSP_LAST_BIT     4'ha
`define HVSP_FIFO_WIDTH   17
`define HVSP_FIFO_DEPTH   16
// Times in ns, counts in core cycles
`define HVSP_CLK_NS       100
`define HVSP_T_MIN_NS     100
`define HVSP_T_ENTRY_NS   8000
`define HVSP_T_WRITE_NS   4000
`define HVSP_SCK_PER_NS   800
`define HVSP_T_GAP_NS     800
`define HVSP_T_MIN_CYC    ((`HVSP_T_MIN_NS + `HVSP_CLK_NS - 1) / `HVSP_CLK_NS)
`define HVSP_T_ENTRY_CYC  ((`HVSP_T_ENTRY_NS + `HVSP_CLK_NS - 1) / `HVSP_CLK_NS)
`define HVSP_T_WRITE_CYC  ((`HVSP_T_WRITE_NS + `HVSP_CLK_NS - 1) / `HVSP_CLK_NS)
`define HVSP_SCK_HALF_CYC ((`HVSP_SCK_PER_NS / 2 + `HVSP_CLK_NS - 1) / `HVSP_CLK_NS)
`define HVSP_T_GAP_CYC    ((`HVSP_T_GAP_NS + `HVSP_CLK_NS - 1) / `HVSP_CLK_NS)
`define HVSP_TOG_LAST     4'h7
// Instruction payloads
`define HVSP_I_LOAD       8'h4c
`define HVSP_I_ADDR_HI    8'h1c
`define HVSP_I_ADDR_LO    8'h0c
`define HVSP_I_DATA_LO    8'h2c
`define HVSP_I_DATA_HI    8'h3c
`define HVSP_I_ARM_LO     8'h64
`define HVSP_I_ARM_HI     8'h74
`define HVSP_I_GO_LO      8'h6c
`define HVSP_I_GO_HI      8'h7c
`define HVSP_I_RD_LO      8'h68
`define HVSP_I_RD_HI      8'h78
// Command payloads of the load step
`define HVSP_C_ERASE      8'h80
`define HVSP_C_WFLASH     8'h10
`define HVSP_C_RFLASH     8'h02
`define HVSP_C_WEE        8'h11
`define HVSP_C_REE        8'h03
`define HVSP_C_RSIG       8'h08
// Memory
`define HVSP_FLASH_WORDS  512
`define HVSP_EE_BYTES     64
`define HVSP_LAST_WORD    9'h1ff
`define HVSP_ERASED       8'hff
`define HVSP_CAL_BYTE     8'h80
// Arbitrary value
`define HVSP_SIG_CODE     8'h5a
`endif

// File: design/hvsp_pkg.sv
`default_nettype none
package hvsp_pkg;
  typedef logic [7:0] hvsp_byte_t;
  typedef enum logic [1:0] {
    DEV_IDLE  = 2'b00,
    DEV_WRITE = 2'b01,
    DEV_ERASE = 2'b10
  } hvsp_dev_st_t;
  typedef enum logic [1:0] {
    TGT_FLO = 2'b00,
    TGT_FHI = 2'b01,
    TGT_EE  = 2'b10
  } hvsp_tgt_t;
  typedef enum logic [2:0] {
    P_OFF  = 3'b000,
    P_PRE  = 3'b001,
    P_TOG  = 3'b010,
    P_HV   = 3'b011,
    P_IDLE = 3'b100,
    P_LOW  = 3'b101,
    P_HIGH = 3'b110,
    P_GAP  = 3'b111
  } hvsp_prog_st_t;
  typedef struct packed {
    hvsp_prog_st_t st;
    logic [7:0]    cnt;
    logic [3:0]    bit_n;
    logic [3:0]    tog;
    logic [10:0]   din;
    logic [10:0]   ins;
    logic [10:0]   rsr;
    logic          sclk;
    logic          hv;
    logic          cap;
    logic          rd_v;
    hvsp_byte_t    rd_d;
    logic          up;
  } hvsp_prog_regs_t;
endpackage : hvsp_pkg
`default_nettype wire

// File: design/hvsp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface hvsp_if;
  logic serial_clock_pin;
  logic serial_data_in_pin;
  logic serial_instruction_in_pin;
  logic serial_data_out_pin;
  logic reset_hv_enable_pin;
  modport dev (
    input  serial_clock_pin,
    input  serial_data_in_pin,
    input  serial_instruction_in_pin,
    input  reset_hv_enable_pin,
    output serial_data_out_pin
  );
  modport prog (
    output serial_clock_pin,
    output serial_data_in_pin,
    output serial_instruction_in_pin,
    output reset_hv_enable_pin,
    input  serial_data_out_pin
  );
endinterface : hvsp_if
`default_nettype wire

// File: design/hvsp_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module hvsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  // Handshakes and fill level
  wire              push     = in_valid & in_ready;
  wire              pop      = out_valid & out_ready;
  wire [AW:0]       next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = cnt != '0;
  assign out_data  = mem[rp];
  // Storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp] <= in_data;
  end
  // Pointers and registered ready
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp       <= '0;
      rp       <= '0;
      cnt      <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      wp       <= push ? wp + AW'(1) : wp;
      rp       <= pop ? rp + AW'(1) : rp;
      cnt      <= next_cnt;
      in_ready <= next_cnt != (AW+1)'(DEPTH);
    end
  end
endmodule : hvsp_fifo
`default_nettype wire

// File: design/hvsp_dev.sv
`timescale 1ns/10ps
`default_nettype none
`include "hvsp_params.svh"
module hvsp_dev (
  input  wire logic CORE_CLK,
  input  wire logic ARST_N,
  hvsp_if.dev       LINK,
  output logic      PROG_ACTIVE,
  output logic      WRITE_BUSY
);
  import hvsp_pkg::*;

  logic [3:0]   sync1;
  logic [3:0]   sync2;
  logic         sck_d;
  logic [3:0]   bit_cnt;
  logic [10:0]  din_sr;
  logic [10:0]  ins_sr;
  logic [10:0]  out_sr;
  logic         sdo;
  hvsp_byte_t   cmd;
  logic [8:0]   addr;
  hvsp_byte_t   wdata;
  logic         armed;
  logic         erase_pend;
  hvsp_dev_st_t state;
  hvsp_dev_st_t next_state;
  hvsp_tgt_t    tgt;
  logic [7:0]   timer;
  logic [7:0]   next_timer;
  logic [8:0]   sweep;
  logic [8:0]   next_sweep;
  logic         we_flo;
  logic         we_fhi;
  logic         we_ee;
  logic [8:0]   mem_a;
  hvsp_byte_t   mem_d;
  hvsp_byte_t   flash_lo [`HVSP_FLASH_WORDS];
  hvsp_byte_t   flash_hi [`HVSP_FLASH_WORDS];
  hvsp_byte_t   ee_mem [`HVSP_EE_BYTES];

  // Two-flop synchronisers for every input pin
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end
    else
    begin
      sync1 <= {LINK.reset_hv_enable_pin, LINK.serial_clock_pin,
                LINK.serial_instruction_in_pin, LINK.serial_data_in_pin};
      sync2 <= sync1;
    end
  end

  // Synchronised pins and clock edge
  wire hv_s     = sync2[3];
  wire sck_s    = sync2[2];
  wire sii_s    = sync2[1];
  wire sdi_s    = sync2[0];
  wire sck_rise = hv_s & sck_s & ~sck_d;

  // Frame shifting and completion
  wire [10:0] next_din   = {din_sr[9:0], sdi_s};
  wire [10:0] next_ins   = {ins_sr[9:0], sii_s};
  wire        last_bit   = bit_cnt == `HVSP_LAST_BIT;
  wire        frame_done = sck_rise & last_bit;
  wire        accept     = frame_done & (state == DEV_IDLE);
  wire [7:0]  ins_b      = next_ins[9:2];
  wire [7:0]  din_b      = next_din[9:2];
  wire [3:0]  next_bit   = !hv_s ? 4'h0 :
                           sck_rise ? (last_bit ? 4'h0 : bit_cnt + 4'h1) : bit_cnt;

  // Instruction decode
  wire is_load  = accept & (ins_b == `HVSP_I_LOAD);
  wire is_ahi   = accept & (ins_b == `HVSP_I_ADDR_HI);
  wire is_alo   = accept & (ins_b == `HVSP_I_ADDR_LO);
  wire is_data  = accept & ((ins_b == `HVSP_I_DATA_LO) | (ins_b == `HVSP_I_DATA_HI));
  wire is_arm   = (ins_b == `HVSP_I_ARM_LO) | (ins_b == `HVSP_I_ARM_HI);
  wire go_lo    = accept & armed & (ins_b == `HVSP_I_GO_LO);
  wire go_hi    = accept & armed & (ins_b == `HVSP_I_GO_HI);
  wire rd_hi    = ins_b == `HVSP_I_RD_HI;
  wire rd_req   = accept & ((ins_b == `HVSP_I_RD_LO) | rd_hi);
  wire wr_flash = (cmd == `HVSP_C_WFLASH) & (go_lo | go_hi);
  wire wr_ee    = (cmd == `HVSP_C_WEE) & go_lo;
  wire start_wr = wr_flash | wr_ee;
  wire start_er = is_load & erase_pend;

  // Control register next values
  wire [7:0]  next_cmd   = is_load ? din_b : cmd;
  wire [8:0]  next_addr  = is_ahi ? {din_b[0], addr[7:0]} :
                           is_alo ? {addr[8], din_b} : addr;
  wire [7:0]  next_wdata = is_data ? din_b : wdata;
  wire        next_armed = accept ? is_arm : armed;
  wire        next_epend = accept ? (go_lo & (cmd == `HVSP_C_ERASE)) : erase_pend;
  wire hvsp_tgt_t wr_tgt = wr_ee ? TGT_EE : (go_hi ? TGT_FHI : TGT_FLO);
  wire hvsp_tgt_t next_tgt = start_wr ? wr_tgt : tgt;

  // Read data selection
  wire [7:0] flo_q   = flash_lo[addr];
  wire [7:0] fhi_q   = flash_hi[addr];
  wire [7:0] ee_q    = ee_mem[addr[5:0]];
  wire       sig_cal = rd_hi & (addr == 9'h000);
  wire [7:0] sig_q   = sig_cal ? `HVSP_CAL_BYTE : `HVSP_SIG_CODE;
  wire [7:0] rd_byte = (cmd == `HVSP_C_REE) ? ee_q :
                       (cmd == `HVSP_C_RSIG) ? sig_q :
                       (rd_hi ? fhi_q : flo_q);
  wire [10:0] next_out = frame_done ? (rd_req ? {1'b0, rd_byte, 2'h0} : 11'h000) :
                         sck_rise ? {out_sr[9:0], 1'b0} : out_sr;

  // Ready shows only between frames; low while busy
  wire next_sdo = !hv_s ? 1'b0 :
                  (bit_cnt != 4'h0) ? out_sr[10] : (next_state == DEV_IDLE);

  // Self-timed write and erase sequencing
  always_comb
  begin
    next_state = state;
    next_timer = timer;
    next_sweep = sweep;
    we_flo     = 1'b0;
    we_fhi     = 1'b0;
    we_ee      = 1'b0;
    mem_a      = addr;
    mem_d      = wdata;
    case (state)
      DEV_IDLE:
      begin
        if (start_er)
        begin
          next_state = DEV_ERASE;
          next_sweep = 9'h000;
        end
        else if (start_wr)
        begin
          next_state = DEV_WRITE;
          next_timer = 8'(`HVSP_T_WRITE_CYC);
          we_ee      = wr_ee;
          mem_d      = `HVSP_ERASED;
        end
      end
      DEV_WRITE:
      begin
        next_timer = timer - 8'h01;
        if (tgt == TGT_FLO)
          mem_d = wdata & flo_q;
        else if (tgt == TGT_FHI)
          mem_d = wdata & fhi_q;
        if (timer == 8'h00)
        begin
          next_state = DEV_IDLE;
          we_flo     = tgt == TGT_FLO;
          we_fhi     = tgt == TGT_FHI;
          we_ee      = tgt == TGT_EE;
        end
      end
      DEV_ERASE:
      begin
        mem_a      = sweep;
        mem_d      = `HVSP_ERASED;
        we_flo     = 1'b1;
        we_fhi     = 1'b1;
        we_ee      = 1'b1;
        next_sweep = sweep + 9'h001;
        if (sweep == `HVSP_LAST_WORD)
          next_state = DEV_IDLE;
      end
      default:
      begin
        next_state = DEV_IDLE;
      end
    endcase
  end

  // Memory arrays
  always_ff @(posedge CORE_CLK)
  begin
    if (we_flo)
      flash_lo[mem_a] <= mem_d;
    if (we_fhi)
      flash_hi[mem_a] <= mem_d;
    if (we_ee)
      ee_mem[mem_a[5:0]] <= mem_d;
  end

  // Frame shifters
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sck_d   <= 1'b0;
      bit_cnt <= 4'h0;
      din_sr  <= 11'h000;
      ins_sr  <= 11'h000;
      out_sr  <= 11'h000;
      sdo     <= 1'b0;
    end
    else
    begin
      sck_d   <= sck_s;
      bit_cnt <= next_bit;
      din_sr  <= sck_rise ? next_din : din_sr;
      ins_sr  <= sck_rise ? next_ins : ins_sr;
      out_sr  <= next_out;
      sdo     <= next_sdo;
    end
  end

  // Command and address registers
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cmd        <= 8'h00;
      addr       <= 9'h000;
      wdata      <= 8'h00;
      armed      <= 1'b0;
      erase_pend <= 1'b0;
      tgt        <= TGT_FLO;
    end
    else
    begin
      cmd        <= next_cmd;
      addr       <= next_addr;
      wdata      <= next_wdata;
      armed      <= next_armed;
      erase_pend <= next_epend;
      tgt        <= next_tgt;
    end
  end

  // Sequencer; reset sweep leaves arrays erased
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state       <= DEV_ERASE;
      timer       <= 8'h00;
      sweep       <= 9'h000;
      PROG_ACTIVE <= 1'b0;
      WRITE_BUSY  <= 1'b1;
    end
    else
    begin
      state       <= next_state;
      timer       <= next_timer;
      sweep       <= next_sweep;
      PROG_ACTIVE <= hv_s;
      WRITE_BUSY  <= next_state != DEV_IDLE;
    end
  end

  assign LINK.serial_data_out_pin = sdo;
endmodule : hvsp_dev
`default_nettype wire

// File: design/hvsp_prog.sv
`timescale 1ns/10ps
`default_nettype none
`include "hvsp_params.svh"
module hvsp_prog (
  input  wire logic              CORE_CLK,
  input  wire logic              ARST_N,
  hvsp_if.prog                   LINK,
  input  wire logic              PROG_EN,
  input  wire logic              CMD_VALID,
  output logic                   CMD_READY,
  input  wire logic              CMD_CAPTURE,
  input  wire hvsp_pkg::hvsp_byte_t CMD_INSTR,
  input  wire hvsp_pkg::hvsp_byte_t CMD_DATA,
  output logic                   RD_VALID,
  output hvsp_pkg::hvsp_byte_t   RD_DATA,
  output logic                   LINK_READY
);
  import hvsp_pkg::*;

  hvsp_prog_regs_t r;
  hvsp_prog_regs_t n;
  logic            sdo_1;
  logic            sdo_s;
  logic            pop;
  logic            f_valid;
  logic [16:0]     f_data;
  wire             cnt_zero = r.cnt == 8'h00;
  wire [7:0]       cnt_dec  = r.cnt - 8'h01;

  // Step queue in front of the serialiser
  hvsp_fifo #(
    .WIDTH (`HVSP_FIFO_WIDTH),
    .DEPTH (`HVSP_FIFO_DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .arst_n    (ARST_N),
    .in_valid  (CMD_VALID),
    .in_ready  (CMD_READY),
    .in_data   ({CMD_CAPTURE, CMD_INSTR, CMD_DATA}),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_data)
  );

  // Entry, framing and exit sequencing
  always_comb
  begin
    n      = r;
    n.rd_v = 1'b0;
    pop    = 1'b0;
    n.cnt  = cnt_zero ? r.cnt : cnt_dec;
    case (r.st)
      P_OFF:
      begin
        n.din = 11'h000;
        n.ins = 11'h000;
        if (PROG_EN)
        begin
          n.st  = P_PRE;
          n.cnt = 8'(`HVSP_T_MIN_CYC);
        end
      end
      P_PRE:
      begin
        if (cnt_zero)
        begin
          n.st  = P_TOG;
          n.tog = 4'h0;
          n.cnt = 8'(`HVSP_SCK_HALF_CYC);
        end
      end
      P_TOG:
      begin
        if (cnt_zero)
        begin
          n.sclk = ~r.sclk;
          n.tog  = r.tog + 4'h1;
          n.cnt  = 8'(`HVSP_SCK_HALF_CYC);
          if (r.tog == `HVSP_TOG_LAST)
          begin
            n.st  = P_HV;
            n.cnt = 8'(`HVSP_T_MIN_CYC);
          end
        end
      end
      P_HV:
      begin
        if (cnt_zero && !r.hv)
        begin
          n.hv  = 1'b1;
          n.cnt = 8'(`HVSP_T_ENTRY_CYC);
        end
        else if (cnt_zero)
        begin
          n.st = P_IDLE;
          n.up = 1'b1;
        end
      end
      P_IDLE:
      begin
        if (!PROG_EN)
        begin
          n.hv = 1'b0;
          n.up = 1'b0;
          n.st = P_OFF;
        end
        else if (f_valid && sdo_s)
        begin
          pop     = 1'b1;
          n.ins   = {1'b0, f_data[15:8], 2'h0};
          n.din   = {1'b0, f_data[7:0], 2'h0};
          n.cap   = f_data[16];
          n.bit_n = 4'h0;
          n.cnt   = 8'(`HVSP_SCK_HALF_CYC);
          n.st    = P_LOW;
        end
      end
      P_LOW:
      begin
        if (cnt_zero)
        begin
          n.sclk = 1'b1;
          n.rsr  = {r.rsr[9:0], sdo_s};
          n.cnt  = 8'(`HVSP_SCK_HALF_CYC);
          n.st   = P_HIGH;
        end
      end
      P_HIGH:
      begin
        if (cnt_zero)
        begin
          n.sclk = 1'b0;
          n.cnt  = 8'(`HVSP_SCK_HALF_CYC);
          n.st   = P_LOW;
          n.din  = {r.din[9:0], 1'b0};
          n.ins  = {r.ins[9:0], 1'b0};
          n.bit_n = r.bit_n + 4'h1;
          if (r.bit_n == `HVSP_LAST_BIT)
          begin
            n.st   = P_GAP;
            n.cnt  = 8'(`HVSP_T_GAP_CYC);
            n.rd_v = r.cap;
            n.rd_d = r.rsr[9:2];
          end
        end
      end
      P_GAP:
      begin
        if (cnt_zero && sdo_s)
          n.st = P_IDLE;
      end
      default:
      begin
        n.st = P_OFF;
      end
    endcase
  end

  // State and data-out synchroniser
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      r     <= '0;
      sdo_1 <= 1'b0;
      sdo_s <= 1'b0;
    end
    else
    begin
      r     <= n;
      sdo_1 <= LINK.serial_data_out_pin;
      sdo_s <= sdo_1;
    end
  end

  // Pins and user outputs straight from flops
  assign LINK.serial_clock_pin          = r.sclk;
  assign LINK.serial_data_in_pin        = r.din[10];
  assign LINK.serial_instruction_in_pin = r.ins[10];
  assign LINK.reset_hv_enable_pin       = r.hv;
  assign RD_VALID                       = r.rd_v;
  assign RD_DATA                        = r.rd_d;
  assign LINK_READY                     = r.up;
endmodule : hvsp_prog
`default_nettype wire

// File: testbench/hvsp_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "hvsp_params.svh"
module hvsp_monitor (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic serial_clock_pin,
  input wire logic serial_data_in_pin,
  input wire logic serial_instruction_in_pin,
  input wire logic serial_data_out_pin,
  input wire logic reset_hv_enable_pin
);
  logic        sclk_q;
  logic [3:0]  tog_cnt;
  logic [3:0]  frm;
  logic [7:0]  hv_cnt;
  logic [7:0]  l_ins;
  logic [7:0]  p_ins;
  logic [7:0]  pp_ins;
  logic [10:0] ins_sh;
  // Short aliases for the link wires
  wire logic        sclk     = serial_clock_pin;
  wire logic        hv       = reset_hv_enable_pin;
  wire logic        din      = serial_data_in_pin;
  wire logic        ins      = serial_instruction_in_pin;
  wire logic        sdo      = serial_data_out_pin;
  // Clock edges, frame position and the last three instruction payloads
  wire logic        rise     = sclk & ~sclk_q;
  wire logic        frm_end  = rise & hv & (frm == `HVSP_LAST_BIT);
  wire logic [10:0] ins_word = {ins_sh[9:0], ins};
  wire logic [7:0]  cur_ins  = ins_word[9:2];
  wire logic [3:0]  next_tog = hv ? 4'h0 : tog_cnt + {3'h0, (sclk != sclk_q) & (tog_cnt != 4'hf)};
  wire logic [7:0]  next_hv  = hv ? hv_cnt + {7'h00, hv_cnt != 8'hff} : 8'h00;
  wire logic [3:0]  next_frm = (!hv || frm_end) ? 4'h0 : frm + {3'h0, rise};
  wire logic        wr_go    = frm_end && (p_ins == `HVSP_I_DATA_LO || p_ins == `HVSP_I_DATA_HI)
                               && (l_ins == `HVSP_I_ARM_LO || l_ins == `HVSP_I_ARM_HI)
                               && (cur_ins == `HVSP_I_GO_LO || cur_ins == `HVSP_I_GO_HI);
  wire logic        er_go    = frm_end && pp_ins == `HVSP_I_LOAD && p_ins == `HVSP_I_ARM_LO
                               && l_ins == `HVSP_I_GO_LO && cur_ins == `HVSP_I_LOAD;
  // Tracking registers
  always_ff @(posedge CORE_CLK or negedge ARST_N)
    if (!ARST_N)
    begin
      sclk_q                 <= 1'b0;
      tog_cnt                <= 4'h0;
      frm                    <= 4'h0;
      hv_cnt                 <= 8'h00;
      ins_sh                 <= 11'h000;
      {pp_ins, p_ins, l_ins} <= 24'h000000;
    end
    else
    begin
      sclk_q                 <= sclk;
      tog_cnt                <= next_tog;
      frm                    <= next_frm;
      hv_cnt                 <= next_hv;
      ins_sh                 <= rise ? ins_word : ins_sh;
      {pp_ins, p_ins, l_ins} <= frm_end ? {p_ins, l_ins, cur_ins} : {pp_ins, p_ins, l_ins};
    end
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);
  // Entry: clock and data quiet as the high voltage arrives
  sequence s_quiet;
    (!sclk && !din) ##1 !din;
  endsequence
  // Device busy shortly after a frame and for a while
  sequence s_busy;
    ##8 (!sdo) [*8];
  endsequence
  entry_toggle_a: assert property ($rose(hv) |-> tog_cnt >= 4'h4)
    else $error("high voltage raised after too few clock toggles");
  entry_quiet_a: assert property ($rose(hv) |-> s_quiet)
    else $error("clock or data not low around high voltage rise");
  entry_wait_a: assert property (rise && hv |-> hv_cnt >= 8'h50)
    else $error("frame started too soon after high voltage");
  exit_order_a: assert property ($fell(hv) |-> !sclk && !sclk_q)
    else $error("high voltage dropped with clock not low");
  rise_sample_a: assert property ($changed(din) || $changed(ins) |-> !sclk)
    else $error("input data changed while clock high");
  frame_pad_a: assert property (rise && hv && (frm == 4'h0 || frm >= 4'h9) |-> !din && !ins)
    else $error("frame padding bit not zero on inputs");
  pad_out_a: assert property (rise && hv && frm >= 4'h9 |-> !sdo)
    else $error("frame trailing bit not zero on output");
  ready_start_a: assert property (rise && hv && frm == 4'h0 |-> sdo)
    else $error("frame started while device busy");
  write_busy_a: assert property (wr_go |-> s_busy)
    else $error("no busy after write step");
  erase_busy_a: assert property (er_go |-> s_busy)
    else $error("no busy after erase step");
endmodule : hvsp_monitor
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "hvsp_params.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %h, expected %h", $time, got, exp); end end
module testbench;
  import hvsp_pkg::*;
  typedef struct {
    hvsp_byte_t cmd;
    logic [8:0] addr;
    hvsp_byte_t ins;
    hvsp_byte_t dat;
  } hvsp_row_t;
  logic        core_clk;
  logic        arst_n;
  logic        prog_en;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_capture;
  logic        rd_valid;
  logic        link_ready;
  logic        prog_active;
  logic        write_busy;
  hvsp_byte_t  cmd_instr;
  hvsp_byte_t  cmd_data;
  hvsp_byte_t  rd_data;
  int          err_count;
  int          n_compared;
  int          bit_n;
  hvsp_byte_t  rd_q[$];
  logic [32:0] frm_q[$];
  logic [10:0] f_ins;
  logic [10:0] f_din;
  logic [10:0] f_sdo;
  // Steps: command, address, data or read instruction, data or expected byte
  hvsp_row_t rows[13] = '{
    '{`HVSP_C_WFLASH, 9'h105, `HVSP_I_DATA_LO, 8'ha5},
    '{`HVSP_C_WFLASH, 9'h105, `HVSP_I_DATA_HI, 8'h3c},
    '{`HVSP_C_RFLASH, 9'h105, `HVSP_I_RD_LO, 8'ha5},
    '{`HVSP_C_RFLASH, 9'h105, `HVSP_I_RD_HI, 8'h3c},
    '{`HVSP_C_WFLASH, 9'h105, `HVSP_I_DATA_LO, 8'h0f},
    '{`HVSP_C_RFLASH, 9'h105, `HVSP_I_RD_LO, 8'h05},
    '{`HVSP_C_RFLASH, 9'h005, `HVSP_I_RD_LO, `HVSP_ERASED},
    '{`HVSP_C_WEE, 9'h03f, `HVSP_I_DATA_LO, 8'h12},
    '{`HVSP_C_REE, 9'h03f, `HVSP_I_RD_LO, 8'h12},
    '{`HVSP_C_WEE, 9'h03f, `HVSP_I_DATA_LO, 8'h34},
    '{`HVSP_C_REE, 9'h03f, `HVSP_I_RD_LO, 8'h34},
    '{`HVSP_C_RSIG, 9'h000, `HVSP_I_RD_HI, `HVSP_CAL_BYTE},
    '{`HVSP_C_RSIG, 9'h000, `HVSP_I_RD_LO, `HVSP_SIG_CODE}
  };
  hvsp_if link ();
  hvsp_dev u_hvsp_dev (.CORE_CLK(core_clk), .ARST_N(arst_n), .LINK(link.dev),
    .PROG_ACTIVE(prog_active), .WRITE_BUSY(write_busy));
  hvsp_prog u_hvsp_prog (.CORE_CLK(core_clk), .ARST_N(arst_n), .LINK(link.prog),
    .PROG_EN(prog_en), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_CAPTURE(cmd_capture), .CMD_INSTR(cmd_instr), .CMD_DATA(cmd_data),
    .RD_VALID(rd_valid), .RD_DATA(rd_data), .LINK_READY(link_ready));
  hvsp_monitor u_hvsp_monitor (.CORE_CLK(core_clk), .ARST_N(arst_n),
    .serial_clock_pin(link.serial_clock_pin), .serial_data_in_pin(link.serial_data_in_pin),
    .serial_instruction_in_pin(link.serial_instruction_in_pin),
    .serial_data_out_pin(link.serial_data_out_pin),
    .reset_hv_enable_pin(link.reset_hv_enable_pin));
  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Collect read answers once settled
  always @(negedge core_clk)
    if (rd_valid === 1'b1)
      rd_q.push_back(rd_data);
  // Gather frames as the device sees them
  always @(posedge link.serial_clock_pin)
  begin
    f_ins = {f_ins[9:0], link.serial_instruction_in_pin};
    f_din = {f_din[9:0], link.serial_data_in_pin};
    f_sdo = {f_sdo[9:0], link.serial_data_out_pin};
    bit_n = (link.reset_hv_enable_pin === 1'b1) ? bit_n + 1 : 0;
    if (bit_n == 11)
    begin
      frm_q.push_back({f_ins, f_din, f_sdo});
      bit_n = 0;
    end
  end
  task automatic finish_test;
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // One step handed to the queue, held until taken
  task automatic push(input logic cap, input hvsp_byte_t ins, input hvsp_byte_t dat);
    int n;
    n = 0;
    @(posedge core_clk);
    #5;
    cmd_capture = cap;
    cmd_instr = ins;
    cmd_data = dat;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 20000)
    begin
      @(posedge core_clk);
      #5;
      n++;
    end
    @(posedge core_clk);
    #5;
    cmd_valid = 1'b0;
    if (n >= 20000)
      err_count++;
  endtask : push
  task automatic wait_lvl(ref logic sig, input logic val);
    int n;
    n = 0;
    while (sig !== val && n < 5000)
    begin
      @(posedge core_clk);
      #5;
      n++;
    end
    if (n >= 5000)
      err_count++;
  endtask : wait_lvl
  task automatic get_rd(input hvsp_byte_t exp);
    int         n;
    hvsp_byte_t d;
    n = 0;
    while (rd_q.size() == 0 && n < 20000)
    begin
      @(posedge core_clk);
      #5;
      n++;
    end
    d = (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx;
    `CHK(d, exp)
  endtask : get_rd
  // Load, address, then write or read one byte
  task automatic run_row(input hvsp_row_t r);
    logic hi;
    logic wr;
    hi = (r.ins == `HVSP_I_DATA_HI) || (r.ins == `HVSP_I_RD_HI);
    wr = (r.cmd == `HVSP_C_WFLASH) || (r.cmd == `HVSP_C_WEE);
    push(1'b0, `HVSP_I_LOAD, r.cmd);
    if (r.cmd != `HVSP_C_WEE && r.cmd != `HVSP_C_REE)
      push(1'b0, `HVSP_I_ADDR_HI, {7'h00, r.addr[8]});
    push(1'b0, `HVSP_I_ADDR_LO, r.addr[7:0]);
    push(1'b0, r.ins, wr ? r.dat : 8'h00);
    if (wr)
      push(1'b0, hi ? `HVSP_I_ARM_HI : `HVSP_I_ARM_LO, 8'h00);
    push(!wr, hi ? `HVSP_I_GO_HI : `HVSP_I_GO_LO, 8'h00);
    if (!wr)
      get_rd(r.dat);
  endtask : run_row
  // Watchdog
  initial
  begin
    #(50000 * 100);
    err_count++;
    finish_test;
  end
  initial
  begin
    {arst_n, prog_en, cmd_valid, cmd_capture, cmd_instr, cmd_data} = 20'h00000;
    repeat (20) @(posedge core_clk);
    `CHK({write_busy, prog_active, link_ready, cmd_ready, rd_valid}, 5'h10)
    #5;
    arst_n = 1'b1;
    wait_lvl(write_busy, 1'b0);
    // Fill the queue while the link is down: five reads, last one short
    push(1'b0, `HVSP_I_LOAD, `HVSP_C_RFLASH);
    push(1'b0, `HVSP_I_ADDR_HI, 8'h00);
    for (int a = 5; a < 10; a++)
    begin
      push(1'b0, `HVSP_I_ADDR_LO, a[7:0]);
      push(1'b0, `HVSP_I_RD_LO, 8'h00);
      if (a < 9)
        push(1'b1, `HVSP_I_GO_LO, 8'h00);
    end
    `CHK(cmd_ready, 1'b0)
    prog_en = 1'b1;
    wait_lvl(link_ready, 1'b1);
    `CHK(prog_active, 1'b1)
    push(1'b1, `HVSP_I_GO_LO, 8'h00);
    for (int i = 0; i < 5; i++)
      get_rd(`HVSP_ERASED);
    `CHK(frm_q[0][32:11], {1'b0, `HVSP_I_LOAD, 2'b00, 1'b0, `HVSP_C_RFLASH, 2'b00})
    `CHK(frm_q[4][32:22], {1'b0, `HVSP_I_GO_LO, 2'b00})
    `CHK(frm_q[4][10:0], {1'b1, `HVSP_ERASED, 2'b00})
    foreach (rows[i])
      run_row(rows[i]);
    // Chip erase in four steps, then both arrays blank
    push(1'b0, `HVSP_I_LOAD, `HVSP_C_ERASE);
    push(1'b0, `HVSP_I_ARM_LO, 8'h00);
    push(1'b0, `HVSP_I_GO_LO, 8'h00);
    push(1'b0, `HVSP_I_LOAD, 8'h00);
    wait_lvl(write_busy, 1'b1);
    repeat (400) @(posedge core_clk);
    #5;
    `CHK(write_busy, 1'b1)
    run_row('{`HVSP_C_RFLASH, 9'h105, `HVSP_I_RD_LO, `HVSP_ERASED});
    run_row('{`HVSP_C_REE, 9'h03f, `HVSP_I_RD_LO, `HVSP_ERASED});
    // Leave programming mode
    prog_en = 1'b0;
    wait_lvl(prog_active, 1'b0);
    `CHK({link.reset_hv_enable_pin, link.serial_clock_pin}, 2'b00)
    // Reset in mid-run, then re-enter and find a blank array
    prog_en = 1'b1;
    wait_lvl(link_ready, 1'b1);
    arst_n = 1'b0;
    @(posedge core_clk);
    #5;
    `CHK({write_busy, prog_active, link_ready, cmd_ready}, 4'h8)
    `CHK(link.reset_hv_enable_pin, 1'b0)
    arst_n = 1'b1;
    run_row('{`HVSP_C_RFLASH, 9'h005, `HVSP_I_RD_LO, `HVSP_ERASED});
    finish_test;
  end
endmodule : testbench
`default_nettype wire
